// ### inc/alu_exec_defs.svh
/*
 * Offsets, field positions, opcodes and reset values of the file-operand execute stage.
 * Assumes it is included by bare name and is the only source of these constants.
 */
`ifndef ALU_EXEC_DEFS_SVH
`define ALU_EXEC_DEFS_SVH

`define ADDR_INSTR 8'h00
`define ADDR_ACCUM 8'h04
`define ADDR_STATUS 8'h08

`define INSTR_RST 14'h0000
`define ACCUM_RST 8'h00
`define FILE_ADDR_RST 7'h00
`define FILE_DATA_RST 8'h00

`define GRP_MSB 13
`define GRP_LSB 12
`define OPC_MSB 11
`define OPC_LSB 8
`define BITOP_MSB 11
`define BITOP_LSB 10
`define BIDX_MSB 9
`define BIDX_LSB 7
`define DEST_BIT 7
`define FADDR_MSB 6
`define INSTR_MSB 13

`define GRP_BYTE 2'h0
`define GRP_BIT 2'h1
`define OPC_ADD 4'h7
`define OPC_AND 4'h5
`define BITOP_CLR 2'h0
`define BITOP_SET 2'h1
`define DEST_ACCUM 1'h0

`define ST_CARRY 0
`define ST_HALF 1
`define ST_ZERO 2
`define ST_BUSY 8
`define ST_BAD 9

`endif

// ### inc/alu_exec_pkg.sv
/*
 * Types shared by the execute stage: state enum, status flags, file port request.
 * Assumes nothing beyond a SystemVerilog compiler; no constants live here.
 */
package alu_exec_pkg;

	typedef enum logic [0:0] {st_idle, st_exec} exec_state_t;

	typedef struct packed {
		logic zero;
		logic half_carry;
		logic carry;
	} flags_t;

	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] wdata;
		logic we;
	} file_port_t;

endpackage

// ### src/alu_exec.sv
/*
 * Execute stage for add/and of accumulator with a file register and bit clear/set of a
 * file register, with an APB slave for the instruction, accumulator and status words.
 * Assumes the file storage answers file_rdata combinationally for the address shown on
 * file_port.addr, and that file_is_port / file_pin_data are decoded for that same address.
 */
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "alu_exec_defs.svh"

// Notes on behaviour
// - opcode 00 0111: accumulator plus file, update carry, half_carry_flag and zero
// - opcode 00 0101: accumulator AND file, update only zero flag
// - destination bit 0: result goes to accumulator, file untouched
// - destination bit 1: result written back to file, accumulator untouched
// - opcode 01 00bb: clear_file_bit forces selected file bit to zero, no flags
// - opcode 01 01bb: set_file_bit forces selected file bit to one, no flags
// - an I/O port operand is taken from pin levels, not the output latch
module alu_exec
(
	input wire logic pclk, // bus and core clock
	input wire logic presetn, // asynchronous reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction, high for write
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	output alu_exec_pkg::file_port_t file_port, // file address, write data, write pulse
	input wire logic [7:0] file_rdata, // file register latch contents
	input wire logic file_is_port, // addressed file is an i/o port
	input wire logic [7:0] file_pin_data, // pin levels of the addressed port
	output logic [7:0] accum, // working accumulator
	output alu_exec_pkg::flags_t flags, // zero, half carry, carry
	output logic busy // instruction in execution
);

	logic [13:0] instr_q, instr_d;
	logic [7:0] accum_q, accum_d;
	alu_exec_pkg::flags_t flags_q, flags_d;
	alu_exec_pkg::file_port_t file_q, file_d;
	alu_exec_pkg::exec_state_t state_q, state_d;
	logic bad_q, bad_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic busy_q, busy_d;

	logic access;
	logic done;
	logic hit_instr;
	logic hit_accum;
	logic hit_status;
	logic unmapped;
	logic [31:0] rd_word;
	logic [7:0] operand;
	logic [8:0] sum;
	logic [4:0] nib_sum;
	logic [7:0] and_res;
	logic [7:0] bit_mask;
	logic [1:0] grp;
	logic [3:0] opc;
	logic [1:0] bitop;
	logic dest_file;
	logic issue;
	logic bad_set;

	logic first_access;
	logic rd_capture;
	logic wr_instr;
	logic wr_accum;
	logic wr_status;
	logic is_add;
	logic is_and;
	logic is_clr;
	logic is_set;
	logic [7:0] clr_res;
	logic [7:0] set_res;

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign file_port = file_q;
	assign accum = accum_q;
	assign flags = flags_q;
	assign busy = busy_q;

	// apb decode; registered pready gives one wait state on every transfer
	always_comb
	begin
		access = psel & penable;
		done = access & pready_q;
		hit_instr = (paddr == `ADDR_INSTR);
		hit_accum = (paddr == `ADDR_ACCUM);
		hit_status = (paddr == `ADDR_STATUS);
		// unaligned and unmapped offsets alike answer with pslverr and change nothing
		unmapped = ~(hit_instr | hit_accum | hit_status);
		rd_word = 32'h0000_0000;
		if (hit_instr)
		begin
			rd_word[`INSTR_MSB:0] = instr_q;
		end
		else if (hit_accum)
		begin
			rd_word[7:0] = accum_q;
		end
		else if (hit_status)
		begin
			rd_word[`ST_CARRY] = flags_q.carry;
			rd_word[`ST_HALF] = flags_q.half_carry;
			rd_word[`ST_ZERO] = flags_q.zero;
			rd_word[`ST_BUSY] = (state_q == alu_exec_pkg::st_exec);
			rd_word[`ST_BAD] = bad_q;
		end
		// the first access cycle raises pready; the edge after it completes the transfer
		first_access = access & ~pready_q;
		rd_capture = first_access & ~pwrite;
		wr_instr = done & pwrite & hit_instr;
		wr_accum = done & pwrite & hit_accum;
		wr_status = done & pwrite & hit_status;
		pready_d = first_access;
		pslverr_d = first_access & unmapped;
		// read data holds between reads, so a slow sampler still sees the last word
		prdata_d = prdata_q;
		if (rd_capture)
		begin
			prdata_d = rd_word;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// instruction field split and datapath
	always_comb
	begin
		grp = instr_q[`GRP_MSB:`GRP_LSB];
		opc = instr_q[`OPC_MSB:`OPC_LSB];
		bitop = instr_q[`BITOP_MSB:`BITOP_LSB];
		dest_file = instr_q[`DEST_BIT];
		// a port modified from itself reads the pins, so input pins lose latched ones
		operand = file_is_port ? file_pin_data : file_rdata;
		sum = {1'b0, accum_q} + {1'b0, operand};
		// half carry is the carry out of the low nibble
		nib_sum = {1'b0, accum_q[3:0]} + {1'b0, operand[3:0]};
		and_res = accum_q & operand;
		// index low bit shares bit 7 with the destination select of the byte group
		bit_mask = 8'h01 << instr_q[`BIDX_MSB:`BIDX_LSB];
		clr_res = operand & ~bit_mask;
		set_res = operand | bit_mask;
		// anything not decoded here falls to the unsupported branch
		is_add = (grp == `GRP_BYTE) && (opc == `OPC_ADD);
		is_and = (grp == `GRP_BYTE) && (opc == `OPC_AND);
		is_clr = (grp == `GRP_BIT) && (bitop == `BITOP_CLR);
		is_set = (grp == `GRP_BIT) && (bitop == `BITOP_SET);
	end

	// execution control: a write to the instruction word issues it, next cycle completes it
	always_comb
	begin
		instr_d = instr_q;
		accum_d = accum_q;
		flags_d = flags_q;
		state_d = state_q;
		bad_d = bad_q;
		bad_set = 1'b0;
		file_d = file_q;
		file_d.we = 1'b0;
		issue = wr_instr;

		if (wr_accum)
		begin
			accum_d = pwdata[7:0];
		end
		// the execute edge and a status write never meet: the next transfer completes
		// three edges after the issuing one at the earliest
		if (wr_status)
		begin
			flags_d.carry = pwdata[`ST_CARRY];
			flags_d.half_carry = pwdata[`ST_HALF];
			flags_d.zero = pwdata[`ST_ZERO];
			if (pwdata[`ST_BAD])
			begin
				bad_d = 1'b0;
			end
		end

		case (state_q)
			// an instruction written while busy would be dropped; bus spacing rules it out
			alu_exec_pkg::st_idle:
			begin
				if (issue)
				begin
					instr_d = pwdata[`INSTR_MSB:0];
					file_d.addr = pwdata[`FADDR_MSB:0];
					state_d = alu_exec_pkg::st_exec;
				end
			end
			alu_exec_pkg::st_exec:
			begin
				// single cycle in this state completes the instruction
				state_d = alu_exec_pkg::st_idle;
				if (is_add)
				begin
					flags_d.carry = sum[8];
					flags_d.half_carry = nib_sum[4];
					flags_d.zero = (sum[7:0] == 8'h00);
					if (dest_file == `DEST_ACCUM)
					begin
						accum_d = sum[7:0];
					end
					else
					begin
						file_d.wdata = sum[7:0];
						file_d.we = 1'b1;
					end
				end
				else if (is_and)
				begin
					flags_d.zero = (and_res == 8'h00);
					if (dest_file == `DEST_ACCUM)
					begin
						accum_d = and_res;
					end
					else
					begin
						file_d.wdata = and_res;
						file_d.we = 1'b1;
					end
				end
				else if (is_clr)
				begin
					file_d.wdata = clr_res;
					file_d.we = 1'b1;
				end
				else if (is_set)
				begin
					file_d.wdata = set_res;
					file_d.we = 1'b1;
				end
				else
				begin
					// other opcodes belong to other units; flag it and leave state alone
					bad_set = 1'b1;
				end
			end
			default:
			begin
				state_d = alu_exec_pkg::st_idle;
			end
		endcase
		// hardware set beats a software clear in the same cycle
		if (bad_set)
		begin
			bad_d = 1'b1;
		end

		// registered so that busy leaves the block straight from a flop
		busy_d = (state_d == alu_exec_pkg::st_exec);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			instr_q <= `INSTR_RST;
			accum_q <= `ACCUM_RST;
			flags_q <= '0;
			state_q <= alu_exec_pkg::st_idle;
			bad_q <= 1'b0;
			busy_q <= 1'b0;
			file_q.addr <= `FILE_ADDR_RST;
			file_q.wdata <= `FILE_DATA_RST;
			file_q.we <= 1'b0;
		end
		else
		begin
			instr_q <= instr_d;
			accum_q <= accum_d;
			flags_q <= flags_d;
			state_q <= state_d;
			bad_q <= bad_d;
			busy_q <= busy_d;
			file_q <= file_d;
		end
	end

endmodule

// ### testbench/alu_exec_chk.sv
/* checker: execute timing and results at the top ports.
   assumes the defs header on the include path; bound by the bench. */
`timescale 1ns/1ps
`include "alu_exec_defs.svh"
module alu_exec_chk
(
	input wire logic pclk, // clock
	input wire logic presetn, // reset
	input wire logic psel, // select
	input wire logic penable, // access
	input wire logic pwrite, // write
	input wire logic [7:0] paddr, // address
	input wire logic [31:0] pwdata, // data
	input wire logic pready, // ready
	input wire alu_exec_pkg::file_port_t file_port, // file port
	input wire logic [7:0] file_rdata, // latch
	input wire logic file_is_port, // port
	input wire logic [7:0] file_pin_data, // pins
	input wire logic [7:0] accum, // accumulator
	input wire alu_exec_pkg::flags_t flags, // flags
	input wire logic busy // busy
);
	logic [13:0] ins_q;
	logic [13:0] ins_d;
	wire issue = psel && penable && pready && pwrite && paddr == `ADDR_INSTR;
	wire [7:0] op = file_is_port ? file_pin_data : file_rdata;
	wire [8:0] sum = accum + op;
	wire [4:0] hs = accum[3:0] + op[3:0];
	wire [7:0] andv = accum & op;
	wire [7:0] bitv = ins_q[10] ? op | 8'h01 << ins_q[9:7] : op & ~(8'h01 << ins_q[9:7]);
	wire [2:0] add_fl = {sum[7:0] == 8'h00, hs[4], sum[8]};
	wire is_add = ins_q[13:8] == {`GRP_BYTE, `OPC_ADD};
	wire is_and = ins_q[13:8] == {`GRP_BYTE, `OPC_AND};
	wire is_bit = ins_q[13:11] == {`GRP_BIT, 1'h0};
	wire to_file = ins_q[`DEST_BIT];
	always_comb ins_d = issue ? pwdata[13:0] : ins_q;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			ins_q <= 14'h0000;
		else
			ins_q <= ins_d;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	busy_pulse_a: assert property (issue |=> busy ##1 !busy)
		else $error("busy not one cycle");
	addr_load_a: assert property (issue |=> file_port.addr == $past(pwdata[6:0]))
		else $error("file address wrong");
	add_accum_a: assert property (busy && is_add && !to_file |=>
		accum == $past(sum[7:0]) && !file_port.we) else $error("add to accum wrong");
	add_flags_a: assert property (busy && is_add |=> flags == $past(add_fl))
		else $error("add flags wrong");
	and_flags_a: assert property (busy && is_and |=> flags.zero == ($past(andv) == 8'h00)
		&& $stable(flags.carry) && $stable(flags.half_carry)) else $error("and flags wrong");
	and_accum_a: assert property (busy && is_and && !to_file |=> accum == $past(andv))
		else $error("and to accum wrong");
	file_dest_a: assert property (busy && to_file && (is_add || is_and) |=> file_port.we
		&& $stable(accum) && file_port.wdata == (is_add ? $past(sum[7:0]) : $past(andv)))
		else $error("file destination wrong");
	bit_op_a: assert property (busy && is_bit |=> file_port.we && $stable(flags)
		&& file_port.wdata == $past(bitv) ##1 !file_port.we) else $error("bit op wrong");
	cover property (busy && is_add && to_file);
	cover property (busy && is_bit && file_is_port);
	cover property (busy && is_and && !to_file);
endmodule

// ### testbench/alu_exec_bench.sv
/* bench: random and corner instructions over apb, results read back.
   assumes design, package, header and checker compiled first. */
`timescale 1ns/1ps
`include "alu_exec_defs.svh"
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin failures++; \
	$display("mismatch at %0t: %h vs %h", $time, g, x); end end
module alu_exec_bench;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic file_is_port = 1'h0, pready, pslverr, busy, err, d, port;
	logic [7:0] paddr = 8'h00, file_rdata = 8'h00, file_pin_data = 8'h00, accum, a, f, pn, wd;
	logic [31:0] pwdata = 32'h0, prdata, rd, r;
	logic [6:0] ad;
	logic [2:0] b, s;
	logic [10:0] e;
	logic [13:0] ins;
	alu_exec_pkg::file_port_t file_port;
	alu_exec_pkg::flags_t flags;
	int failures = 0, n_compared = 0, cyc = 0, n_we = 0, n0, i, k;
	integer seed = 32'h6ff2;
	alu_exec i_alu_exec (.*);
	always #5 pclk = ~pclk;
	// sampled mid-cycle so the edge that updates a flop never races the read
	always @(negedge pclk)
	begin
		cyc <= cyc + 1;
		if (file_port.we === 1'h1)
		begin
			n_we <= n_we + 1;
			wd <= file_port.wdata;
		end
		if (cyc == 20000)
		begin
			failures++;
			give_verdict;
		end
	end
	task give_verdict;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task apb(input logic wr, input logic [7:0] adr, input logic [31:0] dt);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= adr;
		pwdata <= dt;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	function logic [10:0] expect_op(int k, logic [7:0] a, op, logic [2:0] b, st);
		logic [8:0] x;
		logic [4:0] h;
		h = a[3:0] + op[3:0];
		x = k == 0 ? a + op : k == 1 ? a & op : k == 2 ? op & ~(8'h01 << b) : op | 8'h01 << b;
		return {k == 0 ? {x[7:0] == 8'h00, h[4], x[8]} : k == 1 ? {x[7:0] == 8'h00, st[1:0]} : st,
			x[7:0]};
	endfunction
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, `ADDR_ACCUM, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'h0, 8'h0c, 32'h0);
		`CHK(err, 1'h1)
		for (i = 0; i < 200; i++)
		begin
			k = i % 4;
			d = i[2];
			r = $random(seed);
			{a, f, pn, ad} = r[30:0];
			r = $random(seed);
			{b, s, port} = r[6:0];
			// first two passes of each kind use ff and 01, so the add hits carry, half carry and a zero result together
			if (i < 8)
				{a, f, pn} = 24'hff0101;
			@(posedge pclk);
			file_rdata <= f;
			file_pin_data <= pn;
			file_is_port <= port;
			apb(1'h1, `ADDR_ACCUM, {24'h0, a});
			apb(1'h1, `ADDR_STATUS, {29'h0, s});
			ins = k < 2 ? {`GRP_BYTE, k == 1 ? `OPC_AND : `OPC_ADD, d, ad}
				: {`GRP_BIT, k == 3 ? `BITOP_SET : `BITOP_CLR, b, ad};
			n0 = n_we;
			apb(1'h1, `ADDR_INSTR, {18'h0, ins});
			e = expect_op(k, a, port ? pn : f, b, s);
			apb(1'h0, `ADDR_ACCUM, 32'h0);
			`CHK(rd[7:0], k < 2 && !d ? e[7:0] : a)
			apb(1'h0, `ADDR_STATUS, 32'h0);
			`CHK(rd[2:0], e[10:8])
			`CHK(n_we - n0, int'(k > 1 || d))
			if (k > 1 || d)
				`CHK(wd, e[7:0])
			$display("test %0d done", i);
		end
		// a bit test opcode belongs to another unit: sticky flag only, nothing written
		n0 = n_we;
		apb(1'h1, `ADDR_INSTR, 32'h0000_1800);
		apb(1'h0, `ADDR_STATUS, 32'h0);
		`CHK(rd[9:8], 2'h2)
		`CHK(n_we - n0, 0)
		apb(1'h1, `ADDR_STATUS, 32'h0000_0200);
		apb(1'h0, `ADDR_STATUS, 32'h0);
		`CHK(rd[9], 1'h0)
		$display("test unsupported done");
		give_verdict;
	end
endmodule
bind alu_exec alu_exec_chk i_alu_exec_chk (.*);
